// file: core/acq_scan_pkg.sv
package acq_scan_pkg;

	// register map
	localparam logic [7:0] ACQ_CTRL_ADDR = 8'h13;
	localparam int COMPLETE_BIT = 15;
	localparam int TIMEOUT_BIT = 14;
	localparam int READY_BIT = 13;
	localparam int DIAG_HI = 10;
	localparam int DIAG_LO = 8;
	localparam int POLARITY_BIT = 7;
	localparam int OVS_HI = 6;
	localparam int OVS_LO = 4;
	localparam int TRANSFER_BIT = 1;
	localparam int START_BIT = 0;
	localparam logic [15:0] ACQ_CTRL_RESET = 16'h0000;

	// diagnostic selector codes
	localparam logic [2:0] DIAG_SW_SHORT = 3'h1;
	localparam logic [2:0] DIAG_SW_OPEN = 3'h2;
	localparam logic [2:0] DIAG_SENSE_ODD = 3'h5;
	localparam logic [2:0] DIAG_SENSE_EVEN = 3'h6;

	// watchdog timing: expected time per oversample, scaled by the count
	localparam int CLOCK_MHZ = 200;
	localparam int SAMPLE_TIME_NS = 1000;
	localparam int SAMPLE_TIMEOUT_CYC = (SAMPLE_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int TIMER_W = 24;

	typedef enum logic [1:0]
	{
		ACQ_IDLE = 2'b00,
		ACQ_RUN = 2'b01
	} acq_state_type;

	function automatic logic [7:0] oversample_count(input logic [2:0] sel);
		logic [7:0] n;
		n = 8'h01;
		case (sel)
			3'h0: n = 8'h01;
			3'h1: n = 8'h04;
			3'h2: n = 8'h08;
			3'h3: n = 8'h10;
			3'h4: n = 8'h20;
			3'h5: n = 8'h40;
			default: n = 8'h80;
		endcase
		return n;
	endfunction

endpackage

// file: core/acq_sticky_flag.sv
`timescale 1ns/10ps
`default_nettype none
// sticky status bit: hardware sets, a zero written by software clears
module acq_sticky_flag
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic set,
	input wire logic clear,
	output logic flag_r
);
	logic flag_nxt;

	// (R16) set beats clear
	// set is tested first so an event in the clearing cycle survives
	assign flag_nxt = set ? 1'b1 : (clear ? 1'b0 : flag_r);

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			flag_r <= 1'b0;
		else
			flag_r <= flag_nxt;
	end
endmodule
`default_nettype wire

// file: core/acquisition_scan_control.sv
// What this block does
// (R1) set complete flag when acquisition finishes
// (R2) complete flag clears only on zero write
// (R3) no new acquisition while complete flag set
// (R4) timeout flag when acquisition overruns scaled duration
// (R5) timeout flag holds until zero write
// (R6) watchdog disabled by configuration bit
// (R7) ready flag set when results copied
// (R8) all results copied in one transfer
// (R9) ready flag clears on zero write only
// (R10) decode diagnostic selector, four tests
// (R11) diagnostics override enables, polarity; update alerts
// (R12) polarity bit selects bipolar converter range
// (R13) start strobe, reads zero, ignored while running
// (R14) transfer strobe, ignored while acquisition runs
// (R15) oversample code maps to sample count
// (R16) hardware set beats software clear
`timescale 1ns/10ps
`default_nettype none
module acquisition_scan_control
#(
	parameter int SAMPLE_TIMEOUT = acq_scan_pkg::SAMPLE_TIMEOUT_CYC
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic acquisition_watchdog_enable,
	input wire logic conversion_done,
	output logic [15:0] reg_rdata_r,
	output logic reg_rvalid_r,
	output logic acq_start_r,
	output logic acq_active_r,
	output logic results_copy_r,
	output logic balance_alert_update_r,
	output logic diag_override_r,
	output logic [3:0] diag_test_r,
	output logic bipolar_mode_r,
	output logic [7:0] oversample_count_r
);
	import acq_scan_pkg::*;

	//****************************************
	// register decode
	//****************************************
	logic [2:0] diag_sel_r;
	logic polarity_r;
	logic [2:0] ovs_sel_r;
	logic complete_flag, timeout_flag, ready_flag;
	acq_state_type state_r, state_nxt;
	logic [TIMER_W-1:0] timer_r, timer_nxt;

	wire hit_wr = reg_wr && (reg_addr == ACQ_CTRL_ADDR);
	wire hit_rd = reg_rd && (reg_addr == ACQ_CTRL_ADDR);
	wire running = (state_r == ACQ_RUN);
	// (R13) start ignored while running
	// (R3) refused while complete flag set
	wire start_ok = hit_wr && reg_wdata[START_BIT] && !running
		&& !complete_flag;
	// (R14) transfer ignored in acquisition
	wire copy_ok = hit_wr && reg_wdata[TRANSFER_BIT] && !running;
	wire [TIMER_W-1:0] limit = TIMER_W'(SAMPLE_TIMEOUT)
		* TIMER_W'(oversample_count(ovs_sel_r));
	// (R6) watchdog gated by config bit
	wire wd_expire = running && !conversion_done
		&& !acquisition_watchdog_enable && (timer_r >= limit - 1'b1);
	wire finish = running && conversion_done;
	wire diag_on = (diag_sel_r == DIAG_SW_SHORT)
		|| (diag_sel_r == DIAG_SW_OPEN)
		|| (diag_sel_r == DIAG_SENSE_ODD)
		|| (diag_sel_r == DIAG_SENSE_EVEN);
	wire [15:0] read_word = {complete_flag, timeout_flag, ready_flag,
		2'b00, diag_sel_r, polarity_r, ovs_sel_r, 4'h0};

	//****************************************
	// status flags
	//****************************************
	// (R1) complete flag set on finish
	// (R2) cleared only by zero write
	acq_sticky_flag u_complete
	(
		.clock(clock),
		.nrst(nrst),
		.set(finish),
		.clear(hit_wr && !reg_wdata[COMPLETE_BIT]),
		.flag_r(complete_flag)
	);
	// (R4) timeout flag on watchdog expiry
	// (R5) held until zero write
	acq_sticky_flag u_timeout
	(
		.clock(clock),
		.nrst(nrst),
		.set(wd_expire),
		.clear(hit_wr && !reg_wdata[TIMEOUT_BIT]),
		.flag_r(timeout_flag)
	);
	// (R7) ready set with the copy
	// (R9) cleared by zero write
	acq_sticky_flag u_ready
	(
		.clock(clock),
		.nrst(nrst),
		.set(copy_ok),
		.clear(hit_wr && !reg_wdata[READY_BIT]),
		.flag_r(ready_flag)
	);

	//****************************************
	// acquisition sequencer
	//****************************************
	always_comb
	begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		case (state_r)
			ACQ_IDLE:
			begin
				timer_nxt = '0;
				if (start_ok)
					state_nxt = ACQ_RUN;
			end
			ACQ_RUN:
			begin
				// (R4) duration scaled by oversamples
				timer_nxt = timer_r + 1'b1;
				if (finish || wd_expire)
					state_nxt = ACQ_IDLE;
			end
			default: state_nxt = ACQ_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= ACQ_IDLE;
			timer_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
		end
	end

	//****************************************
	// configuration fields
	//****************************************
	// the strobe bits are never stored, so they read back as zero
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			diag_sel_r <= ACQ_CTRL_RESET[DIAG_HI:DIAG_LO];
			polarity_r <= ACQ_CTRL_RESET[POLARITY_BIT];
			ovs_sel_r <= ACQ_CTRL_RESET[OVS_HI:OVS_LO];
		end
		else if (hit_wr)
		begin
			diag_sel_r <= reg_wdata[DIAG_HI:DIAG_LO];
			polarity_r <= reg_wdata[POLARITY_BIT];
			ovs_sel_r <= reg_wdata[OVS_HI:OVS_LO];
		end
	end

	//****************************************
	// outputs
	//****************************************
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata_r <= 16'h0000;
			reg_rvalid_r <= 1'b0;
			acq_start_r <= 1'b0;
			acq_active_r <= 1'b0;
			results_copy_r <= 1'b0;
			balance_alert_update_r <= 1'b0;
			diag_override_r <= 1'b0;
			diag_test_r <= 4'h0;
			bipolar_mode_r <= 1'b0;
			oversample_count_r <= 8'h01;
		end
		else
		begin
			// unmapped reads answer zero
			reg_rdata_r <= hit_rd ? read_word : 16'h0000;
			reg_rvalid_r <= reg_rd;
			acq_start_r <= start_ok;
			acq_active_r <= (state_nxt == ACQ_RUN);
			// (R8) single pulse copies every result
			results_copy_r <= copy_ok;
			// (R11) alerts compared when diagnostic run finishes with conversion_done, not on watchdog expiry
			balance_alert_update_r <= finish && diag_on;
			// (R11) override only during acquisition
			diag_override_r <= (state_nxt == ACQ_RUN) && diag_on;
			// (R10) one-hot test decode
			diag_test_r <= {diag_sel_r == DIAG_SENSE_EVEN,
				diag_sel_r == DIAG_SENSE_ODD,
				diag_sel_r == DIAG_SW_OPEN,
				diag_sel_r == DIAG_SW_SHORT};
			// (R12) bipolar when polarity bit set
			bipolar_mode_r <= polarity_r;
			// (R15) oversample code to count
			oversample_count_r <= oversample_count(ovs_sel_r);
		end
	end

	//****************************************
	// assertions
	//****************************************
	a_complete_sets: assert property (@(posedge clock) disable iff (!nrst) // R1
		finish |=> complete_flag)
		else $error("complete flag not set after finish");
	a_complete_holds: assert property (@(posedge clock) disable iff (!nrst) // R2
		complete_flag && !(hit_wr && !reg_wdata[COMPLETE_BIT]) |=> complete_flag)
		else $error("complete flag dropped without zero write");
	a_start_refused: assert property (@(posedge clock) disable iff (!nrst) // R3
		hit_wr && reg_wdata[START_BIT] && complete_flag |=> !acq_start_r)
		else $error("acquisition started with complete flag set");
	a_timeout_sets: assert property (@(posedge clock) disable iff (!nrst) // R4
		wd_expire |=> timeout_flag && !acq_active_r)
		else $error("watchdog expiry not flagged");
	a_timeout_holds: assert property (@(posedge clock) disable iff (!nrst) // R5
		timeout_flag && !(hit_wr && !reg_wdata[TIMEOUT_BIT]) |=> timeout_flag)
		else $error("timeout flag dropped without zero write");
	a_watchdog_off: assert property (@(posedge clock) disable iff (!nrst) // R6
		acquisition_watchdog_enable && !timeout_flag |=> !timeout_flag)
		else $error("timeout raised with watchdog disabled");
	a_ready_copy: assert property (@(posedge clock) disable iff (!nrst) // R7
		results_copy_r |-> ready_flag)
		else $error("copy without ready flag");
	a_copy_once: assert property (@(posedge clock) disable iff (!nrst) // R8
		results_copy_r |-> !$past(acq_active_r))
		else $error("copy during acquisition");
	a_copy_busy: assert property (@(posedge clock) disable iff (!nrst) // R14
		running && hit_wr && reg_wdata[TRANSFER_BIT] |=> !results_copy_r)
		else $error("copy accepted during acquisition");
	a_ready_keep: assert property (@(posedge clock) disable iff (!nrst) // R9
		ready_flag && hit_wr && reg_wdata[READY_BIT] |=> ready_flag)
		else $error("ready cleared by writing one");
	a_diag_decode: assert property (@(posedge clock) disable iff (!nrst) // R10
		diag_test_r != 4'h0 |-> $onehot(diag_test_r))
		else $error("diagnostic decode not one-hot");
	a_start_busy: assert property (@(posedge clock) disable iff (!nrst) // R13
		running && hit_wr && reg_wdata[START_BIT] |=> !acq_start_r)
		else $error("start accepted while running");
	a_set_wins: assert property (@(posedge clock) disable iff (!nrst) // R16
		copy_ok && !reg_wdata[READY_BIT] |=> ready_flag)
		else $error("ready set lost to clear");
endmodule
`default_nettype wire

// file: sim/conv_model.sv
`timescale 1ns/10ps
`default_nettype none
// converter stand-in: answers lat+1 cycles after an acq_start_r pulse, never if lat is 0
module conv_model
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic acq_start_r,
	input wire logic [7:0] lat,
	output logic conversion_done
);
	logic [7:0] cnt_r;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_r <= 8'h00;
			conversion_done <= 1'b0;
		end
		else
		begin
			conversion_done <= (cnt_r == 8'h01);
			if (acq_start_r)
				cnt_r <= lat;
			else if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule
`default_nettype wire

// file: sim/acquisition_scan_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module acquisition_scan_control_tb;
	import acq_scan_pkg::*;
	logic clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, wd_off = 0;
	logic [7:0] reg_addr = 8'h00, lat = 8'h03, oversample_count_r;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata_r, rv;
	logic reg_rvalid_r, acq_start_r, acq_active_r, results_copy_r;
	logic balance_alert_update_r, diag_override_r, bipolar_mode_r;
	logic conversion_done;
	logic [3:0] diag_test_r;
	logic [31:0] seed = 32'h579B424E;
	logic m_done, m_tmo, m_rdy, m_pol;
	logic [2:0] m_diag, m_ovs;
	int ovs_tab[8] = '{1, 4, 8, 16, 32, 64, 128, 128};
	int error_cnt = 0, tests_run = 0, cyc = 0, e;
	always #2.5 clock = ~clock;
	acquisition_scan_control #(.SAMPLE_TIMEOUT(8)) i_acquisition_scan_control
	(.clock, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.acquisition_watchdog_enable(wd_off), .conversion_done, .reg_rdata_r,
	.reg_rvalid_r, .acq_start_r, .acq_active_r, .results_copy_r,
	.balance_alert_update_r, .diag_override_r, .diag_test_r,
	.bipolar_mode_r, .oversample_count_r);
	conv_model i_conv_model
	(.clock, .nrst, .acq_start_r, .lat, .conversion_done);
	// ****
	// tasks
	// ****
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		t = t ^ (t << 5);
		return t;
	endfunction
	function automatic int diag_hot(input int c);
		return (c == 1) ? 1 : (c == 2) ? 2 : (c == 5) ? 4 : (c == 6) ? 8 : 0;
	endfunction
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			error_cnt++;
			complete_run;
		end
	end
	task chk(input string n, input logic [15:0] s, input logic [15:0] x);
		tests_run++;
		if (s !== x)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	task wrm(input logic [15:0] d);
		wr(ACQ_CTRL_ADDR, d);
		m_done &= d[15];
		m_tmo &= d[14];
		m_rdy &= d[13];
		{m_diag, m_pol, m_ovs} = d[10:4];
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 0;
		#1;
		chk("rvalid", 16'(reg_rvalid_r), 16'h0001);
		rv = reg_rdata_r;
	endtask
	task chk_ctrl;
		rd(ACQ_CTRL_ADDR);
		chk("ctrl", rv, {m_done, m_tmo, m_rdy, 2'h0, m_diag, m_pol, m_ovs, 4'h0});
	endtask
	// an acquisition: start, then count its active cycles from the start
	task go(input logic x, input logic [2:0] ov, input logic [2:0] dg,
		input int n_exp, input logic fin);
		int k;
		e = diag_hot(dg);
		wrm({3'h7, 2'h0, dg, 1'b0, ov, 4'h1});
		#1;
		chk("start", 16'(acq_start_r), 16'(x));
		for (k = 0; k < 300 && acq_active_r === 1'b1; k++)
		begin
			@(posedge clock);
			#1;
			if (k == 0)
				chk("override", 16'(diag_override_r), 16'(e != 0));
		end
		chk("cycles", 16'(k), 16'(n_exp));
		chk("alert", 16'(balance_alert_update_r), 16'(fin && e != 0));
		chk("override end", 16'(diag_override_r), 16'h0000);
		m_done |= fin;
	endtask
	// ****
	// sequence
	// ****
	initial
	begin
		{m_done, m_tmo, m_rdy, m_pol, m_diag, m_ovs} = 0;
		repeat (2) @(posedge clock);
		nrst <= 1;
		chk_ctrl;
		for (int i = 0; i < 8; i++)
		begin
			seed = xorshift(seed);
			wrm({3'h7, 2'h0, 3'(i), seed[7:4], 4'h0});
			chk_ctrl;
			e = diag_hot(i);
			chk("diag", 16'(diag_test_r), 16'(e));
			chk("polar", 16'(bipolar_mode_r), 16'(m_pol));
			chk("ovs", 16'(oversample_count_r), 16'(ovs_tab[m_ovs]));
		end
		$display("test fields done");
		go(1, 3'h0, 3'h1, 5, 1);
		chk_ctrl;
		go(0, 3'h0, 3'h0, 0, 0);
		chk_ctrl;
		wrm(16'h6000);
		chk_ctrl;
		lat <= 8'h00;
		go(1, 3'h1, 3'h5, 32, 0);
		m_tmo = 1;
		chk_ctrl;
		wrm(16'hA000);
		chk_ctrl;
		$display("test acquisition done");
		wrm(16'hE002);
		#1;
		chk("copy", 16'(results_copy_r), 16'h0001);
		m_rdy = 1;
		chk_ctrl;
		wrm(16'hE000);
		chk_ctrl;
		wrm(16'hC000);
		chk_ctrl;
		wrm(16'hC002);
		#1;
		chk("copy", 16'(results_copy_r), 16'h0001);
		m_rdy = 1;
		chk_ctrl;
		wd_off <= 1;
		go(1, 3'h2, 3'h0, 300, 0);
		wrm(16'hE062);
		#1;
		chk("copy", 16'(results_copy_r), 16'h0000);
		chk("active", 16'(acq_active_r), 16'h0001);
		chk_ctrl;
		@(posedge clock);
		nrst <= 0;
		repeat (2) @(posedge clock);
		nrst <= 1;
		{m_done, m_tmo, m_rdy, m_pol, m_diag, m_ovs} = 0;
		#1;
		chk("rst count", 16'(oversample_count_r), 16'h0001);
		chk("rst active", 16'(acq_active_r), 16'h0000);
		rd(8'h14);
		chk("unmapped", rv, 16'h0000);
		wr(8'h14, 16'h0FF0);
		chk_ctrl;
		$display("test watchdog done");
		complete_run;
	end
endmodule
`default_nettype wire
